// ---- hw/pdp_alu.sv ----
// Single-cycle ALU with variable MSB, shifter, OR mask and CRC step.
`timescale 1ns/1ns
`default_nettype none
module pdp_alu (
	input  wire logic          [7:0] a_in,
	input  wire logic          [7:0] b_in,
	input  wire pdp_pkg::pdp_cfg_word_t cfg_in,
	input  wire logic          [2:0] msb_in,
	input  wire logic                cin_in,
	input  wire logic                shin_in,
	input  wire logic          [7:0] or_mask_in,
	input  wire logic          [7:0] poly_in,
	output pdp_pkg::pdp_alu_res_t    res_out
);
	import pdp_pkg::*;

	logic [8:0] wm9;
	logic [7:0] wm;
	logic [7:0] x;
	logic [7:0] y;
	logic       c;
	logic [8:0] sum9;
	logic [7:0] f;
	logic       arith;
	logic       fb;

	always_comb begin
		// width mask from the programmed MSB; bits above it read as zero
		wm9   = (9'h002 << msb_in) - 9'h001;
		wm    = wm9[7:0];
		x     = a_in & wm;
		y     = b_in & wm;
		c     = cin_in;
		arith = 1'b1;
		f     = 8'h00;
		fb    = 1'b0;
		case (cfg_in.func)
			ALU_INC: begin
				y = 8'h00;
				c = 1'b1;
			end
			ALU_DEC: begin
				y = wm;
				c = 1'b0;
			end
			ALU_ADD: begin
				y = b_in & wm;
			end
			ALU_SUB: begin
				y = ~b_in & wm;
				c = 1'b1;
			end
			default: begin
				arith = 1'b0;
			end
		endcase
		sum9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
		case (cfg_in.func)
			ALU_AND:  f = a_in & b_in;
			ALU_OR:   f = a_in | b_in;
			ALU_XOR:  f = a_in ^ b_in;
			ALU_PASS: f = a_in;
			default:  f = sum9[7:0];
		endcase
		f = f & wm;
		res_out.cout  = arith && sum9[msb_in + 1];
		res_out.ovf   = arith && (x[msb_in] == y[msb_in]) && (sum9[msb_in] != x[msb_in]);
		res_out.shout = 1'b0;
		res_out.data  = f;
		if (cfg_in.crc_en) begin
			// one LFSR step; with shin held low this is the pseudo-random sequence
			fb            = a_in[msb_in] ^ shin_in;
			res_out.data  = ({a_in[6:0], 1'b0} & wm) ^ (fb ? (poly_in & wm) : 8'h00);
			res_out.shout = fb;
		end else begin
			case (cfg_in.shift)
				SH_LEFT: begin
					res_out.data  = {f[6:0], shin_in} & wm;
					res_out.shout = f[msb_in];
				end
				SH_RIGHT: begin
					res_out.data         = f >> 1;
					res_out.data[msb_in] = shin_in;
					res_out.shout        = f[0];
				end
				// swap ignores the MSB setting and always works on full bytes
				SH_SWAP: res_out.data = {f[3:0], f[7:4]};
				default: res_out.data = f;
			endcase
		end
		if (cfg_in.mask_en) begin
			res_out.data = res_out.data | or_mask_in;
		end
	end
endmodule // pdp_alu
`default_nettype wire

// ---- hw/pdp_datapath.sv ----
// Datapath slice top: config RAM, registers, compares, FIFOs, status/control.
// Overview of operation
// - eight 16-bit config words, selected per cycle
// - eight ALU functions, inc to pass
// - shift, swap, OR mask after ALU
// - two masked compares, selectable operand pairs
// - zero, ones, overflow; selectable condition outputs
// - programmable MSB for arithmetic and shifts
// - single-cycle CRC or LFSR step, programmable polynomial
// - two four-byte FIFOs, direction per FIFO
// - FIFO status selectable as routed outputs
// - carry, shift, condition chaining to neighbours
// - carry and shift out saved for later cycles
// - six routed inputs and six routed outputs
// - written control bits drive routing outputs
// - status register read-only, shows routed inputs
// - sticky status bits cleared by read
// - separate enables for datapath and status/control
// - eight-bit ALU, one cycle per operation
// - accumulators sink results; data regs only source
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pdp_datapath #(
	parameter int FIFO_DEPTH_P = pdp_pkg::FIFO_DEPTH
) (
	input  wire logic                       clock_in,
	input  wire logic                       resetn_in,
	input  wire logic [pdp_pkg::ADDR_W-1:0] bus_addr_in,
	input  wire logic [pdp_pkg::DATA_W-1:0] bus_wdata_in,
	input  wire logic                       bus_write_in,
	input  wire logic                       bus_read_in,
	output logic      [pdp_pkg::DATA_W-1:0] bus_rdata_out,
	input  wire logic [2:0]                 cfg_addr_in,
	input  wire logic                       shift_in,
	input  wire logic                       carry_in,
	input  wire logic                       cond_chain_in,
	output logic      [pdp_pkg::ROUTE_N-1:0] route_out,
	output logic                            chain_carry_out,
	output logic                            chain_shift_out,
	output logic                            chain_cond_out,
	input  wire logic [7:0]                 status_in,
	output logic      [7:0]                 ctrl_out
);
	import pdp_pkg::*;

	typedef struct packed {
		logic [7:0]                            acc0;
		logic [7:0]                            acc1;
		logic [7:0]                            dat0;
		logic [7:0]                            dat1;
		logic [7:0]                            ctrl;
		logic [7:0]                            sticky_mask;
		logic [7:0]                            sticky;
		logic [7:0]                            or_mask;
		logic [7:0]                            poly;
		logic [7:0]                            cmask0;
		logic [7:0]                            cmask1;
		logic [7:0]                            rdata;
		pdp_static_t                           stat;
		logic [1:0]                            enable;
		logic [CFG_WORDS-1:0][CFG_W-1:0]       cfg_ram;
		logic [ROUTE_N-1:0][COND_SEL_W-1:0]    out_sel;
		logic                                  carry_saved;
		logic                                  shift_saved;
		logic [ROUTE_N-1:0]                    route;
		logic                                  chain_carry;
		logic                                  chain_shift;
		logic                                  chain_cond;
	} pdp_state_t;

	pdp_state_t    r_reg;
	pdp_state_t    r_next;
	pdp_cfg_word_t cw;
	pdp_alu_res_t  alu_res;
	logic [7:0]    src_a;
	logic [7:0]    src_b;
	logic          cin;
	logic          shin;
	logic [7:0]    cmp0_y;
	logic [7:0]    cmp1_y;
	logic [COND_N-1:0] cond;
	logic [7:0]    wm;
	logic [8:0]    wm9;
	logic [7:0]    status_view;
	logic          dp_en;
	logic          sc_en;
	logic          q0_push;
	logic          q0_pop;
	logic          q1_push;
	logic          q1_pop;
	logic [7:0]    q0_data;
	logic [7:0]    q1_data;
	logic          q0_empty;
	logic          q0_full;
	logic          q1_empty;
	logic          q1_full;
	logic          q0_to_acc;
	logic          q1_to_acc;
	logic          wr_hit;
	logic          rd_hit;

	// the sequencer outside may change the address every cycle
	assign cw    = pdp_cfg_word_t'(r_reg.cfg_ram[cfg_addr_in]);
	assign dp_en = r_reg.enable[EN_DATAPATH];
	assign sc_en = r_reg.enable[EN_STATCTRL];

	always_comb begin
		case (cw.src_a)
			SRC_ACC0: src_a = r_reg.acc0;
			SRC_ACC1: src_a = r_reg.acc1;
			SRC_DAT0: src_a = r_reg.dat0;
			default:  src_a = r_reg.dat1;
		endcase
		case (cw.src_b)
			SRC_ACC0: src_b = r_reg.acc0;
			SRC_ACC1: src_b = r_reg.acc1;
			SRC_DAT0: src_b = r_reg.dat0;
			default:  src_b = r_reg.dat1;
		endcase
		case (cw.cin_sel)
			CIN_ZERO:  cin = 1'b0;
			CIN_ONE:   cin = 1'b1;
			CIN_CHAIN: cin = carry_in;
			default:   cin = r_reg.carry_saved;
		endcase
		// the saved selection swaps both serial inputs for time multiplexing
		shin = (cw.cin_sel == CIN_SAVED) ? r_reg.shift_saved : shift_in;
	end

	pdp_alu u_alu (
		.a_in       (src_a),
		.b_in       (src_b),
		.cfg_in     (cw),
		.msb_in     (r_reg.stat.msb),
		.cin_in     (cin),
		.shin_in    (shin),
		.or_mask_in (r_reg.or_mask),
		.poly_in    (r_reg.poly),
		.res_out    (alu_res)
	);

	// direction bit set means output buffer: datapath fills, bus drains
	assign q0_push = r_reg.stat.fifo0_out ? (dp_en && cw.fifo_op && !q0_full)
		: (bus_write_in && bus_addr_in == OFS_FIFO0);
	assign q0_pop  = r_reg.stat.fifo0_out ? (bus_read_in && bus_addr_in == OFS_FIFO0)
		: (dp_en && cw.fifo_op && !q0_empty);
	assign q1_push = r_reg.stat.fifo1_out ? (dp_en && cw.fifo_op && !q1_full)
		: (bus_write_in && bus_addr_in == OFS_FIFO1);
	assign q1_pop  = r_reg.stat.fifo1_out ? (bus_read_in && bus_addr_in == OFS_FIFO1)
		: (dp_en && cw.fifo_op && !q1_empty);
	assign q0_to_acc = !r_reg.stat.fifo0_out && q0_pop;
	assign q1_to_acc = !r_reg.stat.fifo1_out && q1_pop;

	pdp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo0 (
		.clock_in     (clock_in),
		.resetn_in    (resetn_in),
		.push_in      (q0_push),
		.push_data_in (r_reg.stat.fifo0_out ? alu_res.data : bus_wdata_in),
		.pop_in       (q0_pop),
		.data_out     (q0_data),
		.empty_out    (q0_empty),
		.full_out     (q0_full)
	);

	pdp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo1 (
		.clock_in     (clock_in),
		.resetn_in    (resetn_in),
		.push_in      (q1_push),
		.push_data_in (r_reg.stat.fifo1_out ? alu_res.data : bus_wdata_in),
		.pop_in       (q1_pop),
		.data_out     (q1_data),
		.empty_out    (q1_empty),
		.full_out     (q1_full)
	);

	always_comb begin
		wm9    = (9'h002 << r_reg.stat.msb) - 9'h001;
		wm     = wm9[7:0];
		cmp0_y = r_reg.stat.cmp0_pair ? r_reg.acc1 : r_reg.dat0;
		cmp1_y = r_reg.stat.cmp1_pair ? r_reg.acc0 : r_reg.dat1;
		cond   = '0;
		// chained equality needs the neighbour to agree on its bytes too
		cond[COND_CMP0_EQ]  = (((r_reg.acc0 ^ cmp0_y) & r_reg.cmask0) == 8'h00)
			&& (!r_reg.stat.chain_en || cond_chain_in);
		cond[COND_CMP0_LT]  = (r_reg.acc0 & r_reg.cmask0) < (cmp0_y & r_reg.cmask0);
		cond[COND_CMP1_EQ]  = (((r_reg.acc1 ^ cmp1_y) & r_reg.cmask1) == 8'h00);
		cond[COND_CMP1_LT]  = (r_reg.acc1 & r_reg.cmask1) < (cmp1_y & r_reg.cmask1);
		cond[COND_ZERO]     = ((alu_res.data & wm) == 8'h00);
		cond[COND_ONES]     = ((alu_res.data | ~wm) == 8'hFF);
		cond[COND_OVF]      = alu_res.ovf;
		cond[COND_CARRY]    = alu_res.cout;
		cond[COND_SHOUT]    = alu_res.shout;
		cond[COND_Q0_EMPTY] = q0_empty;
		cond[COND_Q0_FULL]  = q0_full;
		cond[COND_Q1_EMPTY] = q1_empty;
		cond[COND_Q1_FULL]  = q1_full;
		cond[COND_C_SAVED]  = r_reg.carry_saved;
		cond[COND_S_SAVED]  = r_reg.shift_saved;
		cond[COND_CHAIN_IN] = cond_chain_in;
		status_view = (r_reg.sticky & r_reg.sticky_mask) | (status_in & ~r_reg.sticky_mask);
	end

	assign wr_hit = bus_write_in;
	assign rd_hit = bus_read_in;

	always_comb begin
		r_next       = r_reg;
		r_next.rdata = 8'h00;
		if (dp_en) begin
			if (cw.wr_acc0) begin
				r_next.acc0 = alu_res.data;
			end
			if (cw.wr_acc1) begin
				r_next.acc1 = alu_res.data;
			end
			if (q0_to_acc) begin
				r_next.acc0 = q0_data;
			end
			if (q1_to_acc) begin
				r_next.acc1 = q1_data;
			end
			r_next.carry_saved = alu_res.cout;
			r_next.shift_saved = alu_res.shout;
			r_next.chain_carry = alu_res.cout;
			r_next.chain_shift = alu_res.shout;
			r_next.chain_cond  = cond[COND_CMP0_EQ];
			for (int i = 0; i < ROUTE_N; i++) begin
				r_next.route[i] = cond[r_reg.out_sel[i]];
			end
		end
		// a read clears the latched bits, but a new event in that cycle survives
		if (rd_hit && bus_addr_in == OFS_STATUS) begin
			r_next.sticky = 8'h00;
		end
		if (sc_en) begin
			r_next.sticky = r_next.sticky | (status_in & r_reg.sticky_mask);
		end
		if (wr_hit) begin
			case (bus_addr_in)
				OFS_ACC0:      r_next.acc0 = bus_wdata_in;
				OFS_ACC1:      r_next.acc1 = bus_wdata_in;
				OFS_DATA0:     r_next.dat0 = bus_wdata_in;
				OFS_DATA1:     r_next.dat1 = bus_wdata_in;
				OFS_CONTROL: begin
					if (sc_en) begin
						r_next.ctrl = bus_wdata_in;
					end
				end
				OFS_STICKY:    r_next.sticky_mask = bus_wdata_in;
				OFS_STATIC:    r_next.stat = pdp_static_t'(bus_wdata_in);
				OFS_ENABLE:    r_next.enable = bus_wdata_in[1:0];
				OFS_OR_MASK:   r_next.or_mask = bus_wdata_in;
				OFS_POLY:      r_next.poly = bus_wdata_in;
				OFS_CMP_MASK0: r_next.cmask0 = bus_wdata_in;
				OFS_CMP_MASK1: r_next.cmask1 = bus_wdata_in;
				default: begin
					if (bus_addr_in[5:4] == OFS_CFG_RAM_HI) begin
						if (bus_addr_in[0]) begin
							r_next.cfg_ram[bus_addr_in[3:1]][15:8] = bus_wdata_in;
						end else begin
							r_next.cfg_ram[bus_addr_in[3:1]][7:0] = bus_wdata_in;
						end
					end else if (bus_addr_in[5:3] == OFS_OUT_SEL_HI && bus_addr_in[2:0] < 3'h6) begin
						r_next.out_sel[bus_addr_in[2:0]] = bus_wdata_in[3:0];
					end
				end
			endcase
		end
		if (rd_hit) begin
			case (bus_addr_in)
				OFS_ACC0:      r_next.rdata = r_reg.acc0;
				OFS_ACC1:      r_next.rdata = r_reg.acc1;
				OFS_DATA0:     r_next.rdata = r_reg.dat0;
				OFS_DATA1:     r_next.rdata = r_reg.dat1;
				OFS_FIFO0:     r_next.rdata = (r_reg.stat.fifo0_out && !q0_empty) ? q0_data : 8'h00;
				OFS_FIFO1:     r_next.rdata = (r_reg.stat.fifo1_out && !q1_empty) ? q1_data : 8'h00;
				OFS_CONTROL:   r_next.rdata = r_reg.ctrl;
				OFS_STATUS:    r_next.rdata = status_view;
				OFS_STICKY:    r_next.rdata = r_reg.sticky_mask;
				OFS_STATIC:    r_next.rdata = r_reg.stat;
				OFS_ENABLE:    r_next.rdata = {6'h00, r_reg.enable};
				OFS_OR_MASK:   r_next.rdata = r_reg.or_mask;
				OFS_POLY:      r_next.rdata = r_reg.poly;
				OFS_CMP_MASK0: r_next.rdata = r_reg.cmask0;
				OFS_CMP_MASK1: r_next.rdata = r_reg.cmask1;
				OFS_FIFO_STAT: r_next.rdata = {4'h0, q1_full, q1_empty, q0_full, q0_empty};
				default: begin
					if (bus_addr_in[5:4] == OFS_CFG_RAM_HI) begin
						r_next.rdata = bus_addr_in[0] ? r_reg.cfg_ram[bus_addr_in[3:1]][15:8]
							: r_reg.cfg_ram[bus_addr_in[3:1]][7:0];
					end else if (bus_addr_in[5:3] == OFS_OUT_SEL_HI && bus_addr_in[2:0] < 3'h6) begin
						r_next.rdata = {4'h0, r_reg.out_sel[bus_addr_in[2:0]]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			r_reg          <= '0;
			r_reg.enable   <= RST_ENABLE;
			r_reg.cmask0   <= RST_CMASK;
			r_reg.cmask1   <= RST_CMASK;
			r_reg.stat.msb <= RST_MSB;
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus_rdata_out   = r_reg.rdata;
	assign route_out       = r_reg.route;
	assign chain_carry_out = r_reg.chain_carry;
	assign chain_shift_out = r_reg.chain_shift;
	assign chain_cond_out  = r_reg.chain_cond;
	assign ctrl_out        = r_reg.ctrl;
endmodule // pdp_datapath
`default_nettype wire

// ---- hw/pdp_fifo.sv ----
// Small synchronous byte FIFO with empty and full flags.
`timescale 1ns/1ns
`default_nettype none
module pdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	input  wire logic             push_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	input  wire logic             pop_in,
	output logic      [WIDTH-1:0] data_out,
	output logic                  empty_out,
	output logic                  full_out
);
	import pdp_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} pdp_fifo_st_t;

	pdp_fifo_st_t r_reg;
	pdp_fifo_st_t r_next;
	logic         do_push;
	logic         do_pop;

	always_comb begin
		r_next  = r_reg;
		// a push into a full fifo is dropped; only the datapath-side caller checks full first
		do_push = push_in && (r_reg.cnt != FULL);
		do_pop  = pop_in && (r_reg.cnt != '0);
		if (do_push) begin
			r_next.mem[r_reg.wp] = push_data_in;
			r_next.wp = (r_reg.wp == LAST) ? '0 : PW'(r_reg.wp + 1'b1);
		end
		if (do_pop) begin
			r_next.rp = (r_reg.rp == LAST) ? '0 : PW'(r_reg.rp + 1'b1);
		end
		if (do_push && !do_pop) begin
			r_next.cnt = CW'(r_reg.cnt + 1'b1);
		end else if (do_pop && !do_push) begin
			r_next.cnt = CW'(r_reg.cnt - 1'b1);
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign data_out  = r_reg.mem[r_reg.rp];
	assign empty_out = (r_reg.cnt == '0);
	assign full_out  = (r_reg.cnt == FULL);
endmodule // pdp_fifo
`default_nettype wire

// ---- pkg/pdp_pkg.sv ----
// Shared constants, types and register map of the programmable datapath slice.
package pdp_pkg;

	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 6;
	localparam int CFG_WORDS    = 8;
	localparam int CFG_W        = 16;
	localparam int FIFO_DEPTH   = 4;
	localparam int ROUTE_N      = 6;
	localparam int COND_N       = 16;
	localparam int COND_SEL_W   = 4;

	localparam logic [ADDR_W-1:0] OFS_ACC0       = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_ACC1       = 6'h01;
	localparam logic [ADDR_W-1:0] OFS_DATA0      = 6'h02;
	localparam logic [ADDR_W-1:0] OFS_DATA1      = 6'h03;
	localparam logic [ADDR_W-1:0] OFS_FIFO0      = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_FIFO1      = 6'h05;
	localparam logic [ADDR_W-1:0] OFS_CONTROL    = 6'h06;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 6'h07;
	localparam logic [ADDR_W-1:0] OFS_STICKY     = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_STATIC     = 6'h09;
	localparam logic [ADDR_W-1:0] OFS_ENABLE     = 6'h0A;
	localparam logic [ADDR_W-1:0] OFS_OR_MASK    = 6'h0B;
	localparam logic [ADDR_W-1:0] OFS_POLY       = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_CMP_MASK0  = 6'h0D;
	localparam logic [ADDR_W-1:0] OFS_CMP_MASK1  = 6'h0E;
	localparam logic [ADDR_W-1:0] OFS_FIFO_STAT  = 6'h0F;
	localparam logic [1:0]        OFS_CFG_RAM_HI = 2'h1;
	localparam logic [2:0]        OFS_OUT_SEL_HI = 3'h4;

	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [1:0] RST_ENABLE = 2'h3;
	localparam logic [7:0] RST_CMASK  = 8'hFF;
	localparam logic [2:0] RST_MSB    = 3'h7;

	localparam int EN_DATAPATH = 0;
	localparam int EN_STATCTRL = 1;

	localparam int COND_CMP0_EQ  = 0;
	localparam int COND_CMP0_LT  = 1;
	localparam int COND_CMP1_EQ  = 2;
	localparam int COND_CMP1_LT  = 3;
	localparam int COND_ZERO     = 4;
	localparam int COND_ONES     = 5;
	localparam int COND_OVF      = 6;
	localparam int COND_CARRY    = 7;
	localparam int COND_SHOUT    = 8;
	localparam int COND_Q0_EMPTY = 9;
	localparam int COND_Q0_FULL  = 10;
	localparam int COND_Q1_EMPTY = 11;
	localparam int COND_Q1_FULL  = 12;
	localparam int COND_C_SAVED  = 13;
	localparam int COND_S_SAVED  = 14;
	localparam int COND_CHAIN_IN = 15;

	typedef enum logic [2:0] {ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB,
		ALU_AND, ALU_OR, ALU_XOR, ALU_PASS} pdp_alu_t;
	typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} pdp_shift_t;
	typedef enum logic [1:0] {SRC_ACC0, SRC_ACC1, SRC_DAT0, SRC_DAT1} pdp_src_t;
	typedef enum logic [1:0] {CIN_ZERO, CIN_ONE, CIN_CHAIN, CIN_SAVED} pdp_cin_t;

	typedef struct packed {
		logic       fifo_op;
		logic       crc_en;
		pdp_cin_t   cin_sel;
		logic       wr_acc1;
		logic       wr_acc0;
		pdp_src_t   src_b;
		pdp_src_t   src_a;
		logic       mask_en;
		pdp_shift_t shift;
		pdp_alu_t   func;
	} pdp_cfg_word_t;

	typedef struct packed {
		logic       fifo1_out;
		logic       fifo0_out;
		logic       chain_en;
		logic       cmp1_pair;
		logic       cmp0_pair;
		logic [2:0] msb;
	} pdp_static_t;

	typedef struct packed {
		logic       ovf;
		logic       shout;
		logic       cout;
		logic [7:0] data;
	} pdp_alu_res_t;

endpackage

// ---- tb/pdp_checker.sv ----
// Port-level assertions for the datapath slice, bound to its top.
`timescale 1ns/1ns
`default_nettype none
module pdp_checker #(
	parameter int FIFO_DEPTH_P = 4
) (
	input wire logic                       clock_in,
	input wire logic                       resetn_in,
	input wire logic [pdp_pkg::ADDR_W-1:0] bus_addr_in,
	input wire logic [pdp_pkg::DATA_W-1:0] bus_wdata_in,
	input wire logic                       bus_write_in,
	input wire logic                       bus_read_in,
	input wire logic [pdp_pkg::DATA_W-1:0] bus_rdata_out,
	input wire logic [pdp_pkg::ROUTE_N-1:0] route_out,
	input wire logic                       chain_carry_out,
	input wire logic                       chain_shift_out,
	input wire logic                       chain_cond_out,
	input wire logic [7:0]                 status_in,
	input wire logic [7:0]                 ctrl_out
);
	import pdp_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] smask_reg;
	logic [1:0] en_reg;
	// shadow copies of the sticky mask and enables, as the slice sees them
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			smask_reg <= 8'h00;
			en_reg    <= 2'h3;
		end else if (bus_write_in && bus_addr_in == OFS_STICKY) begin
			smask_reg <= bus_wdata_in;
		end else if (bus_write_in && bus_addr_in == OFS_ENABLE) begin
			en_reg <= bus_wdata_in[1:0];
		end
	end
	chk_rdata_idle:
		assert property (!$past(bus_read_in) |-> bus_rdata_out == 8'h00)
		else $error("read data outside answer cycle");
	chk_status_live:
		assert property (bus_read_in && bus_addr_in == OFS_STATUS && smask_reg == 8'h00
			|=> bus_rdata_out == $past(status_in)) else $error("live status mismatch");
	chk_sticky_hold:
		assert property (bus_read_in && bus_addr_in == OFS_STATUS && smask_reg == 8'hFF
			&& $past(smask_reg) == 8'hFF && en_reg[1] && $past(en_reg[1])
			|=> (bus_rdata_out & $past(status_in, 2)) == $past(status_in, 2))
		else $error("sticky bit lost");
	chk_ctrl_write:
		assert property (bus_write_in && bus_addr_in == OFS_CONTROL && en_reg[1]
			|=> ctrl_out == $past(bus_wdata_in)) else $error("control write lost");
	chk_ctrl_hold:
		assert property (!(bus_write_in && bus_addr_in == OFS_CONTROL && en_reg[1])
			|=> $stable(ctrl_out)) else $error("control changed unasked");
	chk_frozen_route:
		assert property (!en_reg[0] |=> $stable(route_out) && $stable(chain_carry_out)
			&& $stable(chain_shift_out) && $stable(chain_cond_out))
		else $error("outputs moved while disabled");
	chk_reset_quiet:
		assert property ($rose(resetn_in) |-> route_out == 6'h00 && ctrl_out == 8'h00
			&& !chain_carry_out) else $error("outputs not quiet after reset");
	chk_fifo_flags:
		assert property (bus_read_in && bus_addr_in == OFS_FIFO_STAT |=> bus_rdata_out[7:4] == 4'h0
			&& bus_rdata_out[1:0] != 2'h3 && bus_rdata_out[3:2] != 2'h3)
		else $error("fifo flags inconsistent");
endmodule // pdp_checker
bind pdp_datapath pdp_checker #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) chk (.clock_in, .resetn_in,
	.bus_addr_in, .bus_wdata_in, .bus_write_in, .bus_read_in, .bus_rdata_out, .route_out,
	.chain_carry_out, .chain_shift_out, .chain_cond_out, .status_in, .ctrl_out);
`default_nettype wire

// ---- tb/pdp_partner.sv ----
// Sequencer and routing model feeding the slice's routed inputs.
`timescale 1ns/1ns
`default_nettype none
module pdp_partner (
	input  wire logic       clock_in,
	input  wire logic       rand_in,
	input  wire logic [2:0] sel_in,
	input  wire logic [7:0] stat_in,
	output logic      [2:0] cfg_addr_out,
	output logic      [7:0] status_out,
	output logic            shift_out,
	output logic            carry_out,
	output logic            chain_out
);
	integer      seed = 97805;
	logic [13:0] rnd  = 14'h0000;
	// new routed values just after each edge, like registered state logic
	always @(posedge clock_in) rnd <= 14'($random(seed));
	assign cfg_addr_out = rand_in ? rnd[2:0] : sel_in;
	assign status_out   = rand_in ? rnd[10:3] : stat_in;
	assign shift_out    = rand_in & rnd[11];
	assign carry_out    = rand_in & rnd[12];
	assign chain_out    = rand_in & rnd[13];
endmodule // pdp_partner
`default_nettype wire

// ---- tb/programmable_8bit_datapath_test.sv ----
// Self-checking bench for the programmable datapath slice.
`timescale 1ns/1ns
`default_nettype none
module programmable_8bit_datapath_test;
	import pdp_pkg::*;
	logic       clock_in = 1'b0, resetn_in = 1'b0, bus_write_in = 1'b0, bus_read_in = 1'b0;
	logic       rand_on = 1'b0, rd_d = 1'b0, shift_w, carry_w, chain_w, c_out, s_out, q_out;
	logic [5:0] bus_addr_in = 6'h00, route_out;
	logic [7:0] bus_wdata_in = 8'h00, stat = 8'h00, bus_rdata_out, ctrl_out, status_w, va, vb, ve;
	logic [2:0] sel = 3'h0, cfg_addr;
	logic [7:0] exp_q[$];
	int         err_total = 0, checks_done = 0, cycles = 0, f, s;
	always #25 clock_in = ~clock_in;
	pdp_datapath #(.FIFO_DEPTH_P(4)) dut (.clock_in, .resetn_in, .bus_addr_in, .bus_wdata_in,
		.bus_write_in, .bus_read_in, .bus_rdata_out, .cfg_addr_in(cfg_addr), .shift_in(shift_w),
		.carry_in(carry_w), .cond_chain_in(chain_w), .route_out, .chain_carry_out(c_out),
		.chain_shift_out(s_out), .chain_cond_out(q_out), .status_in(status_w), .ctrl_out);
	pdp_partner seq (.clock_in, .rand_in(rand_on), .sel_in(sel), .stat_in(stat),
		.cfg_addr_out(cfg_addr), .status_out(status_w), .shift_out(shift_w),
		.carry_out(carry_w), .chain_out(chain_w));
	task automatic check(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clock_in) rd_d <= bus_read_in;
	// answer stands one cycle only, so compare mid-cycle
	always @(negedge clock_in) if (rd_d) check("read", bus_rdata_out, exp_q.pop_front());
	always @(posedge clock_in) if (++cycles > 3000) begin
		err_total++;
		conclude();
	end
	task automatic tick(input int n);
		bus_read_in <= 1'b0;
		bus_write_in <= 1'b0;
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus_addr_in <= a;
		bus_wdata_in <= d;
		bus_write_in <= 1'b1;
		bus_read_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus_addr_in <= a;
		bus_read_in <= 1'b1;
		bus_write_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic do_reset;
		resetn_in <= 1'b0;
		tick(12);
		resetn_in <= 1'b1;
		tick(1);
	endtask
	// one word in slot 1, run for one cycle, then read the destination
	task automatic op(input logic [15:0] cw, input logic [7:0] a, b, input logic [5:0] dst,
		input logic [7:0] e, input int rt);
		wr(OFS_DATA0, a);
		wr(OFS_DATA1, b);
		wr(6'h12, cw[7:0]);
		wr(6'h13, cw[15:8]);
		sel <= 3'h1;
		tick(1);
		sel <= 3'h0;
		#1;
		if (rt >= 0) check("route", {6'h00, route_out[1:0] & 2'(rt >> 2)}, {6'h00, 2'(rt)});
		if (rt == 15) check("chain carry", {7'h00, c_out}, 8'h01);
		rd(dst, e);
		tick(1);
	endtask
	function automatic logic [7:0] alu(input int f, input logic [7:0] a, b);
		case (f)
			0: return a + 8'h01;
			1: return a - 8'h01;
			2: return a + b;
			3: return a - b;
			4: return a & b;
			5: return a | b;
			6: return a ^ b;
			default: return a;
		endcase
	endfunction
	initial begin
		do_reset();
		rd(OFS_ENABLE, 8'h03);
		rd(OFS_CMP_MASK0, 8'hFF);
		rd(OFS_STATIC, 8'h07);
		rd(OFS_FIFO_STAT, 8'h05);
		rd(6'h3F, 8'h00);
		wr(6'h20, 8'h04);
		wr(6'h21, 8'h07);
		wr(OFS_OR_MASK, 8'h10);
		$display("reset values done");
		for (int i = 0; i < 12; i++) begin
			va = 8'h3C + 8'(i * 37);
			vb = 8'hA7 - 8'(i * 19);
			f = i < 8 ? i : 7;
			s = i < 8 ? 0 : i - 8;
			ve = alu(f, va, vb);
			if (s == 1) ve = {ve[6:0], 1'b0};
			if (s == 2) ve = {1'b0, ve[7:1]};
			if (s == 3) ve = {ve[3:0], ve[7:4]};
			if (i >= 8) ve = ve | 8'h10;
			op(16'h0B80 | 16'(f) | 16'(s << 3) | (i >= 8 ? 16'h0020 : 16'h0000), va, vb,
				OFS_ACC1, ve, 4 | int'(ve == 8'h00));
		end
		$display("alu functions done");
		wr(OFS_ENABLE, 8'h02);
		op(16'h0B80, 8'h11, 8'h22, OFS_ACC1, ve, -1);
		wr(OFS_ENABLE, 8'h03);
		wr(OFS_STATIC, 8'h03);
		op(16'h0B80, 8'h0F, 8'h00, OFS_ACC1, 8'h00, 15);
		wr(OFS_STATIC, 8'h07);
		wr(OFS_POLY, 8'h07);
		wr(6'h21, 8'h08);
		op(16'h4B80, 8'h85, 8'h00, OFS_ACC1, 8'h0D, 10);
		$display("msb and crc done");
		for (int i = 0; i < 5; i++) wr(OFS_FIFO0, 8'hC0 + 8'(i));
		rd(OFS_FIFO_STAT, 8'h06);
		for (int i = 0; i < 4; i++) op(16'h8000, 8'h00, 8'h00, OFS_ACC0, 8'hC0 + 8'(i), -1);
		rd(OFS_FIFO_STAT, 8'h05);
		wr(OFS_STATIC, 8'h87);
		op(16'h8087, 8'h5A, 8'h00, OFS_FIFO1, 8'h5A, -1);
		rd(OFS_FIFO1, 8'h00);
		wr(OFS_STATIC, 8'h07);
		$display("fifo done");
		wr(OFS_CONTROL, 8'hA5);
		wr(OFS_ENABLE, 8'h01);
		wr(OFS_CONTROL, 8'h3C);
		wr(OFS_ENABLE, 8'h03);
		tick(1);
		#1 check("control", ctrl_out, 8'hA5);
		stat <= 8'h96;
		tick(1);
		rd(OFS_STATUS, 8'h96);
		wr(OFS_STICKY, 8'hFF);
		stat <= 8'h01;
		tick(1);
		stat <= 8'h00;
		rd(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_STICKY, 8'h00);
		$display("status and control done");
		rand_on <= 1'b1;
		tick(300);
		// reset again while routed inputs keep moving
		do_reset();
		rand_on <= 1'b0;
		rd(OFS_ENABLE, 8'h03);
		tick(2);
		$display("random run done");
		conclude();
	end
endmodule // programmable_8bit_datapath_test
`default_nettype wire
